//--- logic/nand_bank_ctrl.sv
// NAND flash bank controller: AHB slave, write FIFO and flash cycle sequencer
// Function
// - Address line 17 is address latch
// - Address line 16 is command latch when line 17 is low
// - Two NAND banks, each own chip select
// - Sample ready/busy input from flash
// - One multiplexed bidirectional 8/16-bit bus
// - Split 32-bit access into device-width beats
// - Each bank window is 256 megabytes
// - Bank split into attribute and common halves
// - Only lowest 256K of each space used
// - Address bits 17:16 select area
// - Command-area write gives one command cycle
// - Address-area write gives one address cycle
// - Data area reused; flash increments column
// - Full address is four byte cycles
// - Everything clocked by the AHB clock
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Synchronous FIFO
module op_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_reg;
	logic [AW:0] rptr_reg;

	// Extra pointer bit tells full from empty
	assign in_ready = (wptr_reg ^ rptr_reg) != {1'b1, {AW{1'b0}}};
	assign out_valid = wptr_reg != rptr_reg;
	assign out_data = mem[rptr_reg[AW-1:0]];

	// Storage, written only on accepted pushes
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (out_valid && out_ready) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end
endmodule

// =========================================================
// Top level
module nand_bank_ctrl
	import nand_bank_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wide16,
	output logic addr_latch,
	output logic cmd_latch,
	output logic [1:0] bank_chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [15:0] nand_data_out,
	output logic nand_data_oe,
	input wire logic [15:0] nand_data_in,
	input wire logic flash_ready_busy_in
);
	ahb_state_t ahb_state_reg;
	seq_state_t seq_state_reg;
	nand_op_t req_reg, op_reg, fifo_out;
	logic push_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic rd_req_reg, rd_done_reg;
	logic [1:0] beats_reg, beat_reg;
	logic [2:0] tmr_reg;
	logic [31:0] rd_acc_reg;
	logic [15:0] din_meta_reg, din_sync_reg;
	logic rb_meta_reg, rb_sync_reg;
	logic hit, in_window, req_take;

	// Last beat index (beats minus one): zero for command/address, else bytes over width less one
	function automatic logic [1:0] beat_count(input logic [1:0] area, input logic [1:0] size,
			input logic w16);
		logic [2:0] bytes;
		bytes = 3'h1 << size;
		if (area != AREA_DATA || bytes == 3'h1 || (w16 && bytes == 3'h2)) begin
			beat_count = 2'h0;
		end else if (w16) begin
			beat_count = 2'h1;
		end else begin
			beat_count = 2'(bytes - 3'h1);
		end
	endfunction

	// =========================================================
	// Pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			din_meta_reg <= DOUT_RESET;
			din_sync_reg <= DOUT_RESET;
			rb_meta_reg <= 1'b0;
			rb_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= nand_data_in;
			din_sync_reg <= din_meta_reg;
			rb_meta_reg <= flash_ready_busy_in;
			rb_sync_reg <= rb_meta_reg;
		end
	end

	// =========================================================
	// AHB slave
	// Bank windows of 256 MB; both halves decode alike, only low 256K live
	assign hit = hsel && htrans[1] && hready;
	assign in_window = (haddr[BANK_SEL_HI:BANK_SEL_LO] == BANK_A_SEL ||
		haddr[BANK_SEL_HI:BANK_SEL_LO] == BANK_B_SEL) &&
		haddr[UNUSED_HI:UNUSED_LO] == '0;

	// Every write pays at least one wait state so the pushed word is the real data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ahb_state_reg <= A_IDLE;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= RDATA_RESET;
			req_reg <= '0;
			rd_req_reg <= 1'b0;
		end else begin
			unique case (ahb_state_reg)
				A_IDLE: begin
					hresp <= 1'b0;
					if (hit) begin
						req_reg.area <= haddr[AREA_HI:AREA_LO];
						req_reg.bank <= haddr[BANK_SEL_LO] ^ BANK_A_SEL[0];
						req_reg.size <= hsize[1:0];
						req_reg.lane <= haddr[1:0];
						req_reg.wr <= hwrite;
						req_reg.data <= '0;
						if (!in_window) begin
							hreadyout <= 1'b0;
							hresp <= 1'b1;
							ahb_state_reg <= A_ERR;
						end else if (hwrite) begin
							hreadyout <= 1'b0;
							ahb_state_reg <= A_WDATA;
						end else if (haddr[AREA_HI:AREA_LO] == AREA_DATA) begin
							hreadyout <= 1'b0;
							rd_req_reg <= 1'b1;
							ahb_state_reg <= A_RD;
						end else begin
							hrdata <= RDATA_RESET; // Command/address areas read zero
						end
					end
				end
				A_WDATA: begin
					if (fifo_in_ready) begin
						hreadyout <= 1'b1;
						ahb_state_reg <= A_IDLE;
					end
				end
				A_RD: begin
					if (req_take) begin
						rd_req_reg <= 1'b0;
					end
					if (rd_done_reg) begin
						hrdata <= rd_acc_reg << {req_reg.lane, 3'h0};
						hreadyout <= 1'b1;
						ahb_state_reg <= A_IDLE;
					end
				end
				A_ERR: begin
					hreadyout <= 1'b1;
					ahb_state_reg <= A_IDLE;
				end
			endcase
		end
	end

	// =========================================================
	// Write queue; full FIFO holds the data phase
	assign push_valid = ahb_state_reg == A_WDATA;
	nand_op_t push_op;
	always_comb begin
		push_op = req_reg;
		push_op.data = hwdata >> {req_reg.lane, 3'h0};
	end

	op_fifo #(.WIDTH($bits(nand_op_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data(push_op),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// =========================================================
	// Flash cycle sequencer; reads go only after queued writes drain
	assign fifo_out_ready = seq_state_reg == S_IDLE;
	assign req_take = seq_state_reg == S_IDLE && !fifo_out_valid && rd_req_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_state_reg <= S_IDLE;
			op_reg <= '0;
			beats_reg <= 2'h0;
			beat_reg <= 2'h0;
			tmr_reg <= 3'h0;
			rd_acc_reg <= RDATA_RESET;
			rd_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= 1'b0;
			unique case (seq_state_reg)
				S_IDLE: begin
					beat_reg <= 2'h0;
					tmr_reg <= 3'h0;
					if (fifo_out_valid || req_take) begin
						op_reg <= fifo_out_valid ? fifo_out : req_reg;
						beats_reg <= fifo_out_valid ?
							beat_count(fifo_out.area, fifo_out.size, wide16) :
							beat_count(req_reg.area, req_reg.size, wide16);
						rd_acc_reg <= RDATA_RESET;
						// Only data cycles wait; status/reset commands go while busy
						seq_state_reg <= ((fifo_out_valid ? fifo_out.area : req_reg.area)
							== AREA_DATA) ? S_WAITRB : S_SETUP;
					end
				end
				S_WAITRB: begin
					// Busy raised by the last strobe is not yet through the sync stages
					if (tmr_reg != 3'(RB_SETTLE_CYC - 1)) begin
						tmr_reg <= tmr_reg + 3'h1;
					end else if (rb_sync_reg) begin
						tmr_reg <= 3'h0;
						seq_state_reg <= S_SETUP;
					end
				end
				S_SETUP: begin
					tmr_reg <= tmr_reg + 3'h1;
					if (tmr_reg == 3'(SETUP_CYC - 1)) begin
						tmr_reg <= 3'h0;
						seq_state_reg <= S_STROBE;
					end
				end
				S_STROBE: begin
					tmr_reg <= tmr_reg + 3'h1;
					if (tmr_reg == 3'(STROBE_CYC - 1)) begin
						tmr_reg <= 3'h0;
						seq_state_reg <= S_HOLD;
					end
				end
				S_HOLD: begin
					tmr_reg <= tmr_reg + 3'h1;
					// Synced bus still shows the value from inside the strobe
					if (tmr_reg == 3'h0 && !op_reg.wr) begin
						if (wide16) begin
							rd_acc_reg[{beat_reg[0], 4'h0} +: 16] <= din_sync_reg;
						end else begin
							rd_acc_reg[{beat_reg, 3'h0} +: 8] <= din_sync_reg[7:0];
						end
					end
					if (tmr_reg == 3'(HOLD_CYC - 1)) begin
						tmr_reg <= 3'h0;
						if (beat_reg == beats_reg) begin
							rd_done_reg <= !op_reg.wr;
							seq_state_reg <= S_IDLE;
						end else begin
							beat_reg <= beat_reg + 2'h1;
							op_reg.data <= wide16 ? op_reg.data >> 16 : op_reg.data >> 8;
							seq_state_reg <= S_WAITRB;
						end
					end
				end
				default: seq_state_reg <= S_IDLE;
			endcase
		end
	end

	// =========================================================
	// Pin drivers, one cycle behind the sequencer state
	logic active;
	assign active = seq_state_reg inside {S_SETUP, S_STROBE, S_HOLD};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_latch <= 1'b0;
			cmd_latch <= 1'b0;
			bank_chip_select_n <= 2'h3;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			nand_data_out <= DOUT_RESET;
			nand_data_oe <= 1'b0;
		end else begin
			addr_latch <= active && op_reg.area[1];
			cmd_latch <= active && op_reg.area == AREA_CMD;
			bank_chip_select_n <= active ? ~(2'h1 << op_reg.bank) : 2'h3;
			read_strobe_n <= !(seq_state_reg == S_STROBE && !op_reg.wr);
			write_strobe_n <= !(seq_state_reg == S_STROBE && op_reg.wr);
			nand_data_oe <= active && op_reg.wr;
			// Command and address bytes drive the low lane only
			nand_data_out <= (wide16 && op_reg.area == AREA_DATA) ?
				op_reg.data[15:0] : {8'h00, op_reg.data[7:0]};
		end
	end

	// =========================================================
	// Assertions
	sequence wr_pulse;
		!write_strobe_n [*4] ##1 write_strobe_n;
	endsequence

	sequence rd_pulse;
		!read_strobe_n [*4] ##1 read_strobe_n;
	endsequence

	a_write_pulse_len: assert property (@(posedge clk) disable iff (rst)
		$fell(write_strobe_n) |-> wr_pulse and (bank_chip_select_n != 2'h3) [*5])
		else $error("write strobe width or chip select wrong");

	a_read_pulse_len: assert property (@(posedge clk) disable iff (rst)
		$fell(read_strobe_n) |-> rd_pulse)
		else $error("read strobe width wrong");

	a_cs_one_bank: assert property (@(posedge clk) disable iff (rst)
		$onehot0(~bank_chip_select_n))
		else $error("two chip selects active");

	a_latch_exclusive: assert property (@(posedge clk) disable iff (rst)
		addr_latch |-> !cmd_latch && !read_strobe_n == 1'b0 && bank_chip_select_n != 2'h3)
		else $error("address latch outside address write");

	a_cmd_single: assert property (@(posedge clk) disable iff (rst)
		$fell(write_strobe_n) && cmd_latch |-> ##4 (seq_state_reg == S_IDLE) [*1])
		else $error("command area gave more than one cycle");

	a_bus_turn: assert property (@(posedge clk) disable iff (rst)
		!read_strobe_n |-> !nand_data_oe)
		else $error("bus driven during read strobe");

	a_busy_stall: assert property (@(posedge clk) disable iff (rst)
		seq_state_reg == S_WAITRB && !rb_sync_reg |=> seq_state_reg == S_WAITRB)
		else $error("data beat started while busy");

	a_bad_window: assert property (@(posedge clk) disable iff (rst)
		hit && ahb_state_reg == A_IDLE && !in_window |=> hresp && !hreadyout ##1 hresp && hreadyout)
		else $error("out of window access not refused");

	a_word_beats: assert property (@(posedge clk) disable iff (rst)
		seq_state_reg == S_IDLE && fifo_out_valid && fifo_out.area == AREA_DATA &&
		fifo_out.size == 2'h2 && !wide16 |=> beats_reg == 2'h3)
		else $error("word not split into four byte beats");

endmodule

`default_nettype wire

//--- logic/nand_bank_pkg.sv
// Constants and carrier types for the NAND bank controller
package nand_bank_pkg;

	// =========================================================
	// Address decode
	localparam logic [3:0] BANK_A_SEL = 4'h7;
	localparam logic [3:0] BANK_B_SEL = 4'h8;
	localparam int BANK_SEL_HI = 31;
	localparam int BANK_SEL_LO = 28;
	localparam int SPACE_BIT = 27;
	localparam int UNUSED_HI = 26;
	localparam int UNUSED_LO = 18;
	localparam int AREA_HI = 17;
	localparam int AREA_LO = 16;
	localparam logic [1:0] AREA_DATA = 2'h0;
	localparam logic [1:0] AREA_CMD = 2'h1;

	// =========================================================
	// Strobe timing
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 10;
	localparam int STROBE_NS = 40;
	localparam int HOLD_NS = 10;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	// Ready input lags two sync stages; a fresh busy needs three cycles to show
	localparam int RB_SETTLE_CYC = 3;

	// =========================================================
	// Buffering and reset values
	localparam int FIFO_DEPTH = 8;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [15:0] DOUT_RESET = 16'h0000;

	// One queued flash operation
	typedef struct packed {
		logic [1:0] area;
		logic bank;
		logic [1:0] size;
		logic [1:0] lane;
		logic wr;
		logic [31:0] data;
	} nand_op_t;

	typedef enum logic [2:0] {S_IDLE, S_WAITRB, S_SETUP, S_STROBE, S_HOLD} seq_state_t;
	typedef enum logic [1:0] {A_IDLE, A_WDATA, A_RD, A_ERR} ahb_state_t;

endpackage

//--- verification/nand_flash_bank_controller_test.sv
// Self-checking bench for the NAND bank controller
`timescale 1ns/1ps
`default_nettype none

module nand_flash_bank_controller_test;
	typedef struct packed {
		logic [31:0] a;
		logic [2:0] s;
		logic [31:0] d;
		logic [1:0] k;
		logic [15:0] w;
		logic [7:0] n;
		logic b;
	} row_t;
	logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, wide16, rb, bank, rsp;
	logic addr_latch, cmd_latch, read_strobe_n, write_strobe_n, nand_data_oe;
	logic [1:0] htrans, cs_n, kind;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [15:0] dout, fdrv, bus, word;
	logic [7:0] cnt, base;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int wlow = 0;
	int t0;
	// Cmd, address bytes low first with cycle two upper nibble low, lanes
	row_t rows [10] = '{
		'{32'h7001_0000, 3'h0, 32'h0000_0090, 2'h1, 16'h0090, 8'h01, 1'h0},
		'{32'h7002_0000, 3'h0, 32'h0000_0000, 2'h2, 16'h0000, 8'h01, 1'h0},
		'{32'h7003_0000, 3'h0, 32'h0000_0008, 2'h2, 16'h0008, 8'h01, 1'h0},
		'{32'h7002_0000, 3'h0, 32'h0000_0012, 2'h2, 16'h0012, 8'h01, 1'h0},
		'{32'h7002_0000, 3'h0, 32'h0000_0003, 2'h2, 16'h0003, 8'h01, 1'h0},
		'{32'h7001_0002, 3'h0, 32'h0060_0000, 2'h1, 16'h0060, 8'h01, 1'h0},
		'{32'h8801_0000, 3'h0, 32'h0000_0080, 2'h1, 16'h0080, 8'h01, 1'h1},
		'{32'h7801_0000, 3'h0, 32'h0000_0000, 2'h1, 16'h0000, 8'h01, 1'h0},
		'{32'h7000_0000, 3'h2, 32'h4433_2211, 2'h0, 16'h0044, 8'h04, 1'h0},
		'{32'h7000_0002, 3'h1, 32'h6655_0000, 2'h0, 16'h0066, 8'h02, 1'h0}
	};
	logic [7:0] busy_cmd [2] = '{8'h10, 8'hd0};

	// =========================================================
	// Design, far side and wire
	assign hready = hreadyout;
	assign bus = nand_data_oe ? dout : fdrv;
	nand_bank_ctrl DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wide16(wide16),
		.addr_latch(addr_latch), .cmd_latch(cmd_latch), .bank_chip_select_n(cs_n),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.nand_data_out(dout), .nand_data_oe(nand_data_oe), .nand_data_in(bus),
		.flash_ready_busy_in(rb));
	nand_flash_model flash (.clk(clk), .cs_n(cs_n), .ale(addr_latch), .cle(cmd_latch),
		.we_n(write_strobe_n), .re_n(read_strobe_n), .bus(bus), .drive(fdrv), .rb(rb),
		.cnt(cnt), .kind(kind), .word(word), .bank(bank));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// =========================================================
	// Checking and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic timeout;
		n_errors++;
		results();
	endtask

	// One AHB transfer; result sampled at the edge that ends the data phase
	task automatic xfer(input logic [31:0] a, input logic [2:0] s, input logic w,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= s;
		@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			if (hreadyout === 1'b1)
				break;
		end
		if (i == 400)
			timeout();
		rsp = hresp;
		rdv = hrdata;
	endtask

	task automatic wait_cnt(input logic [7:0] target);
		int i;
		for (i = 0; i < 300 && cnt !== target; i++)
			@(posedge clk);
		if (i == 300)
			timeout();
	endtask

	// Strobe width, select and bus direction during every strobe
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!rst && (write_strobe_n & read_strobe_n) === 1'b0) begin
			wlow++;
			check(cs_n != 2'h3, 1'b1);
			check(nand_data_oe, !write_strobe_n);
		end else if (wlow != 0) begin
			check(wlow, 4);
			wlow = 0;
		end
	end

	// =========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		wide16 = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0000_0000;
		repeat (20) @(posedge clk);
		check({hreadyout, hresp, cs_n, read_strobe_n, write_strobe_n, nand_data_oe,
			addr_latch, cmd_latch}, 9'h178);
		check(hrdata, 32'h0000_0000);
		rst <= 1'b0;
		foreach (rows[r]) begin
			base = cnt;
			xfer(rows[r].a, rows[r].s, 1'b1, rows[r].d);
			check(rsp, 1'b0);
			wait_cnt(base + rows[r].n);
			check(kind, rows[r].k);
			check(word, rows[r].w);
			check(bank, rows[r].b);
		end
		// Outside the bank windows or above the low 256K: refused, nothing sent
		base = cnt;
		xfer(32'h9000_0000, 3'h0, 1'b1, 32'h0000_0011);
		check(rsp, 1'b1);
		xfer(32'h7004_0000, 3'h0, 1'b1, 32'h0000_0011);
		check(rsp, 1'b1);
		repeat (20) @(posedge clk);
		check(cnt, base);
		// Program and erase confirms leave the part busy; reads must stall
		foreach (busy_cmd[j]) begin
			xfer(32'h7001_0000, 3'h0, 1'b1, {24'h000000, busy_cmd[j]});
			t0 = cyc;
			xfer(32'h7000_0000, 3'h0, 1'b0, 32'h0000_0000);
			check(cyc - t0 >= 30, 1'b1);
			check(rdv[7:0], 8'h40 + j[7:0]);
		end
		// Back-to-back read on the same address sees the next column
		xfer(32'h7000_0000, 3'h0, 1'b0, 32'h0000_0000);
		check(rdv[7:0], 8'h42);
		// Sixteen-bit device: width is static, so change it under reset
		@(posedge clk);
		rst <= 1'b1;
		wide16 <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		base = cnt;
		xfer(32'h7000_0000, 3'h2, 1'b1, 32'h4433_2211);
		wait_cnt(base + 8'h02);
		check(word, 16'h4433);
		xfer(32'h7001_0000, 3'h0, 1'b1, 32'h0000_ff70);
		wait_cnt(base + 8'h03);
		check(word, 16'h0070);
		results();
	end
endmodule

`default_nettype wire

//--- verification/nand_flash_model.sv
// Behavioural model of an 8-bit NAND flash on the bank bus
`timescale 1ns/1ps
`default_nettype none

module nand_flash_model #(
	parameter int BUSY_CYC = 30
) (
	input wire logic clk,
	input wire logic [1:0] cs_n,
	input wire logic ale,
	input wire logic cle,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [15:0] bus,
	output logic [15:0] drive,
	output logic rb,
	output logic [7:0] cnt,
	output logic [1:0] kind,
	output logic [15:0] word,
	output logic bank
);
	logic we_d = 1'b1;
	logic re_d = 1'b1;
	logic [7:0] col = 8'h00;
	logic [15:0] last = 16'h0000;
	int busy = 0;

	// =========================================================
	// Cycle capture
	initial begin
		cnt = 8'h00;
		kind = 2'h0;
		word = 16'h0000;
		bank = 1'b0;
	end

	// A cycle counts when the write strobe rises; latches still held then
	always @(posedge clk) begin
		we_d <= we_n;
		re_d <= re_n;
		last <= drive;
		if (busy != 0)
			busy <= busy - 1;
		if (we_n && !we_d && cs_n != 2'h3) begin
			cnt <= cnt + 8'h01;
			kind <= {ale, cle};
			word <= bus;
			bank <= ~cs_n[1];
			// Confirms 10 and d0 on a command cycle make the part busy unless it is already busy
			if (cle && busy == 0 && (bus[7:0] == 8'h10 || bus[7:0] == 8'hd0))
				busy <= BUSY_CYC;
		end
		// Column advances by itself after each read
		if (re_n && !re_d)
			col <= col + 8'h01;
	end

	// Ready only once the internal operation ends
	assign rb = (busy == 0);
	// Released bus flips so a stale value never passes
	assign drive = (!re_n && cs_n != 2'h3) ? {8'h00, 8'h40 + col} : ~last;
endmodule

`default_nettype wire
